// ===== core/wdt_top.v
// Watchdog timer with AXI4-Lite register access, refresh sequence and underflow action
//
// Overview of operation
// - The counter reloads on a 00h-then-FFh refresh write pair, on block reset and on underflow.
// - With autostart disabled the counter and prescaler stay stopped until the start register is written.
// - With autostart enabled counting begins right after reset ends without software.
// - The autostart option comes only from the option byte strap and software cannot change it.
// - With the CPU-clock source the counter holds its value in stop and wait mode.
// - With the sub-clock source the counter holds only in stop mode and runs on in wait mode.
// - Underflow raises an interrupt when the reset select bit is 0 and a reset when it is 1.
// - The prescaler clears only on block reset, so a refresh period may differ by one prescale.
// - CPU-clock mode counts down from 32768 at the CPU clock divided by 16 or by 128.
// - Sub-clock mode counts at the sub-clock divided by 32 from 512, 1024, 2048 or 4096.
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ns
`include "wdt_defines.vh"
module wdt_top
#(
    parameter DIV_FAST = `WDT_DIV_FAST,
    parameter DIV_SLOW = `WDT_DIV_SLOW,
    parameter DIV_SUB = `WDT_DIV_SUB,
    parameter [15:0] CNT_CPU = `WDT_CNT_CPU
)
(
    input wire MCLK,
    input wire SYS_RST,
    input wire [7:0] STARTUP_OPTION_BYTE,
    input wire SUBCLOCK_INPUT,
    input wire STOP_MODE,
    input wire WAIT_MODE,
    input wire [7:0] S_AXI_AWADDR,
    input wire S_AXI_AWVALID,
    output reg S_AXI_AWREADY,
    input wire [31:0] S_AXI_WDATA,
    input wire [3:0] S_AXI_WSTRB,
    input wire S_AXI_WVALID,
    output reg S_AXI_WREADY,
    output reg [1:0] S_AXI_BRESP,
    output reg S_AXI_BVALID,
    input wire S_AXI_BREADY,
    input wire [7:0] S_AXI_ARADDR,
    input wire S_AXI_ARVALID,
    output reg S_AXI_ARREADY,
    output reg [31:0] S_AXI_RDATA,
    output reg [1:0] S_AXI_RRESP,
    output reg S_AXI_RVALID,
    input wire S_AXI_RREADY,
    output reg WDT_IRQ,
    output reg WDT_RESET
);

////////////////////////////////////////////////////////////////////////////////
// Declarations
reg [7:0] aw_addr;
reg aw_got;
reg [31:0] w_data;
reg [3:0] w_strb;
reg w_got;
reg [`WDT_CTL_WIDTH-1:0] wdt_control_reg;
reg [`WDT_ST_WIDTH-1:0] status;
reg [`WDT_ST_WIDTH-1:0] mask;
reg [15:0] count;
reg running;
reg strap_taken;
reg autostart_disable;
reg [7:0] startup_option_byte;
reg refresh_armed;
reg sub_s1;
reg sub_s2;
reg sub_s3;
wire prescaler_div_select;
wire sub_src;
wire count_value_select_lo;
wire count_value_select_hi;
wire underflow_reset_select;
wire do_write;
wire wr_refresh;
wire wr_start;
wire wr_control;
wire wr_status;
wire wr_mask;
wire wr_mapped;
wire refresh_ok;
wire refresh_bad;
wire sub_edge;
wire count_enable;
wire tick;
wire underflow;
wire [`WDT_ST_WIDTH-1:0] status_set;
reg [15:0] reload_value;
reg [31:0] next_rdata;
reg next_rmapped;
assign prescaler_div_select = wdt_control_reg[`WDT_CTL_DIV_SEL];
assign sub_src = wdt_control_reg[`WDT_CTL_SUB_SRC];
assign count_value_select_lo = wdt_control_reg[`WDT_CTL_CVS_LO];
assign count_value_select_hi = wdt_control_reg[`WDT_CTL_CVS_HI];
assign underflow_reset_select = wdt_control_reg[`WDT_CTL_URS];

////////////////////////////////////////////////////////////////////////////////
// Bus write channel
assign do_write = aw_got & w_got & ~S_AXI_BVALID;
assign wr_refresh = do_write & (aw_addr == `WDT_ADDR_REFRESH) & w_strb[0];
assign wr_start = do_write & (aw_addr == `WDT_ADDR_START);
assign wr_control = do_write & (aw_addr == `WDT_ADDR_CONTROL) & w_strb[0];
assign wr_status = do_write & (aw_addr == `WDT_ADDR_STATUS) & w_strb[0];
assign wr_mask = do_write & (aw_addr == `WDT_ADDR_MASK) & w_strb[0];
// Word-aligned map with no holes up to the option byte
assign wr_mapped = (aw_addr <= `WDT_ADDR_OPTION);

always @(posedge MCLK or posedge SYS_RST)
begin
    if (SYS_RST)
    begin
        aw_addr <= 8'h00;
        aw_got <= 1'b0;
        w_data <= 32'h00000000;
        w_strb <= 4'h0;
        w_got <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY <= 1'b1;
        S_AXI_BVALID <= 1'b0;
        S_AXI_BRESP <= `WDT_RESP_OKAY;
    end
    else
    begin
        if (S_AXI_AWVALID & S_AXI_AWREADY)
        begin
            aw_addr <= {S_AXI_AWADDR[7:2], 2'h0};
            aw_got <= 1'b1;
            S_AXI_AWREADY <= 1'b0;
        end
        if (S_AXI_WVALID & S_AXI_WREADY)
        begin
            w_data <= S_AXI_WDATA;
            w_strb <= S_AXI_WSTRB;
            w_got <= 1'b1;
            S_AXI_WREADY <= 1'b0;
        end
        if (do_write)
        begin
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP <= wr_mapped ? `WDT_RESP_OKAY : `WDT_RESP_SLVERR;
        end
        if (S_AXI_BVALID & S_AXI_BREADY)
        begin
            S_AXI_BVALID <= 1'b0;
            aw_got <= 1'b0;
            w_got <= 1'b0;
            S_AXI_AWREADY <= 1'b1;
            S_AXI_WREADY <= 1'b1;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Bus read channel
always @*
begin
    next_rdata = 32'h00000000;
    next_rmapped = 1'b1;
    case ({S_AXI_ARADDR[7:2], 2'h0})
        `WDT_ADDR_REFRESH, `WDT_ADDR_START: next_rdata = 32'h00000000;
        `WDT_ADDR_CONTROL: next_rdata[`WDT_CTL_WIDTH-1:0] = wdt_control_reg;
        `WDT_ADDR_STATUS: next_rdata[`WDT_ST_WIDTH-1:0] = status;
        `WDT_ADDR_MASK: next_rdata[`WDT_ST_WIDTH-1:0] = mask;
        `WDT_ADDR_COUNT: next_rdata[15:0] = count;
        `WDT_ADDR_STATE: next_rdata[2:0] = {refresh_armed, autostart_disable, running};
        `WDT_ADDR_OPTION: next_rdata[7:0] = startup_option_byte;
        default: next_rmapped = 1'b0;
    endcase
end

always @(posedge MCLK or posedge SYS_RST)
begin
    if (SYS_RST)
    begin
        S_AXI_ARREADY <= 1'b1;
        S_AXI_RVALID <= 1'b0;
        S_AXI_RDATA <= 32'h00000000;
        S_AXI_RRESP <= `WDT_RESP_OKAY;
    end
    else
    begin
        if (S_AXI_ARVALID & S_AXI_ARREADY)
        begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA <= next_rdata;
            S_AXI_RRESP <= next_rmapped ? `WDT_RESP_OKAY : `WDT_RESP_SLVERR;
        end
        else if (S_AXI_RVALID & S_AXI_RREADY)
        begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_ARREADY <= 1'b1;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Control, strap capture and start
always @(posedge MCLK or posedge SYS_RST)
begin
    if (SYS_RST)
    begin
        wdt_control_reg <= `WDT_CTL_RESET;
        mask <= `WDT_MASK_RESET;
        strap_taken <= 1'b0;
        autostart_disable <= 1'b0;
        startup_option_byte <= 8'h00;
        running <= 1'b0;
    end
    else
    begin
        if (wr_control)
            wdt_control_reg <= w_data[`WDT_CTL_WIDTH-1:0];
        if (wr_mask)
            mask <= w_data[`WDT_ST_WIDTH-1:0];
        if (!strap_taken)
        begin
            strap_taken <= 1'b1;
            startup_option_byte <= STARTUP_OPTION_BYTE;
            autostart_disable <= STARTUP_OPTION_BYTE[`WDT_OPT_AUTOSTART_BIT];
            running <= ~STARTUP_OPTION_BYTE[`WDT_OPT_AUTOSTART_BIT];
        end
        else if (wr_start)
            running <= 1'b1;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Refresh sequence
// two-write refresh
assign refresh_ok = wr_refresh & refresh_armed & (w_data[7:0] == `WDT_REFRESH_SECOND);
assign refresh_bad = wr_refresh & ~refresh_armed & (w_data[7:0] == `WDT_REFRESH_SECOND);

always @(posedge MCLK or posedge SYS_RST)
begin
    if (SYS_RST)
        refresh_armed <= 1'b0;
    else if (wr_refresh)
        refresh_armed <= (w_data[7:0] == `WDT_REFRESH_FIRST);
end

////////////////////////////////////////////////////////////////////////////////
// Count source and down-counter
always @(posedge MCLK or posedge SYS_RST)
begin
    if (SYS_RST)
    begin
        sub_s1 <= 1'b0;
        sub_s2 <= 1'b0;
        sub_s3 <= 1'b0;
    end
    else
    begin
        sub_s1 <= SUBCLOCK_INPUT;
        sub_s2 <= sub_s1;
        sub_s3 <= sub_s2;
    end
end

assign sub_edge = sub_s2 & ~sub_s3;
// CPU source holds in stop and wait
// sub source holds in stop only
assign count_enable = running & ~STOP_MODE & ~(WAIT_MODE & ~sub_src);

// prescaler cleared by block reset only
wdt_prescaler #(
    .DIV_FAST(DIV_FAST),
    .DIV_SLOW(DIV_SLOW),
    .DIV_SUB(DIV_SUB)
) u_prescaler (
    .clk(MCLK),
    .rst(SYS_RST),
    .enable(count_enable),
    .sub_mode(sub_src),
    .div_sel(prescaler_div_select),
    .sub_edge(sub_edge),
    .tick(tick)
);

always @*
begin
    reload_value = CNT_CPU;
    if (sub_src)
    begin
        case ({count_value_select_hi, count_value_select_lo})
            2'h0: reload_value = `WDT_CNT_SUB0;
            2'h1: reload_value = `WDT_CNT_SUB1;
            2'h2: reload_value = `WDT_CNT_SUB2;
            2'h3: reload_value = `WDT_CNT_SUB3;
            default: reload_value = `WDT_CNT_SUB0;
        endcase
    end
end

assign underflow = tick & count_enable & (count == 16'h0000);
// reload on reset, refresh and underflow
always @(posedge MCLK or posedge SYS_RST)
begin
    if (SYS_RST)
        count <= `WDT_CNT_CPU;
    else if (refresh_ok | underflow)
        count <= reload_value;
    else if (tick & count_enable)
        count <= count - 16'h0001;
end

////////////////////////////////////////////////////////////////////////////////
// Underflow action, status and interrupt
// interrupt or reset by select bit
assign status_set[`WDT_ST_UNDERFLOW] = underflow & ~underflow_reset_select;
assign status_set[`WDT_ST_BAD_REFRESH] = refresh_bad;

always @(posedge MCLK or posedge SYS_RST)
begin
    if (SYS_RST)
    begin
        status <= `WDT_ST_RESET;
        WDT_IRQ <= 1'b0;
        WDT_RESET <= 1'b0;
    end
    else
    begin
        status <= (status & ~(w_data[`WDT_ST_WIDTH-1:0] & {`WDT_ST_WIDTH{wr_status}}))
                  | status_set;
        WDT_IRQ <= |(status & mask);
        WDT_RESET <= underflow & underflow_reset_select;
    end
end

endmodule

// ===== core/wdt_defines.vh
// Register map, field positions, reset values and counts of the watchdog block
`ifndef WDT_DEFINES_VH
`define WDT_DEFINES_VH

// Register byte addresses
`define WDT_ADDR_REFRESH 8'h00
`define WDT_ADDR_START 8'h04
`define WDT_ADDR_CONTROL 8'h08
`define WDT_ADDR_STATUS 8'h0C
`define WDT_ADDR_MASK 8'h10
`define WDT_ADDR_COUNT 8'h14
`define WDT_ADDR_STATE 8'h18
`define WDT_ADDR_OPTION 8'h1C

// Address of the option byte in the flash map (kept for software reference)
`define WDT_OPTION_BYTE_ADDR 16'hFFFF
`define WDT_OPT_AUTOSTART_BIT 0

// Control register fields
`define WDT_CTL_DIV_SEL 0
`define WDT_CTL_SUB_SRC 1
`define WDT_CTL_CVS_LO 2
`define WDT_CTL_CVS_HI 3
`define WDT_CTL_URS 4
`define WDT_CTL_WIDTH 5
`define WDT_CTL_RESET 5'h00

// Status and mask fields
`define WDT_ST_UNDERFLOW 0
`define WDT_ST_BAD_REFRESH 1
`define WDT_ST_WIDTH 2
`define WDT_ST_RESET 2'h0
`define WDT_MASK_RESET 2'h0

// Refresh sequence values
`define WDT_REFRESH_FIRST 8'h00
`define WDT_REFRESH_SECOND 8'hFF

// Prescaler divisors
`define WDT_DIV_FAST 16
`define WDT_DIV_SLOW 128
`define WDT_DIV_SUB 32

// Counter start values
`define WDT_CNT_CPU 16'h8000
`define WDT_CNT_SUB0 16'h0200
`define WDT_CNT_SUB1 16'h0400
`define WDT_CNT_SUB2 16'h0800
`define WDT_CNT_SUB3 16'h1000

// Bus responses
`define WDT_RESP_OKAY 2'h0
`define WDT_RESP_SLVERR 2'h2

`endif

// ===== core/wdt_prescaler.v
// Prescaler that turns CPU clock cycles or sub-clock edges into counter ticks
`timescale 1ns/1ns
module wdt_prescaler
#(
    parameter DIV_FAST = 16,
    parameter DIV_SLOW = 128,
    parameter DIV_SUB = 32
)
(
    input wire clk,
    input wire rst,
    input wire enable,
    input wire sub_mode,
    input wire div_sel,
    input wire sub_edge,
    output reg tick
);

reg [7:0] count;
wire [7:0] limit;
wire step;

assign limit = sub_mode ? (DIV_SUB[7:0] - 8'h01) :
               (div_sel ? (DIV_SLOW[7:0] - 8'h01) : (DIV_FAST[7:0] - 8'h01));
assign step = enable & (sub_mode ? sub_edge : 1'b1);

// Cleared only by the block reset, never by a refresh
always @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        count <= 8'h00;
        tick <= 1'b0;
    end
    else
    begin
        tick <= 1'b0;
        if (step)
        begin
            if (count >= limit)
            begin
                count <= 8'h00;
                tick <= 1'b1;
            end
            else
            begin
                count <= count + 8'h01;
            end
        end
    end
end

endmodule

// ===== verification/wdt_properties.sv
// Concurrent checks on the watchdog block ports
`timescale 1ns/1ns
module wdt_properties
(
    input logic MCLK,
    input logic SYS_RST,
    input logic STOP_MODE,
    input logic S_AXI_AWREADY,
    input logic S_AXI_WREADY,
    input logic [1:0] S_AXI_BRESP,
    input logic S_AXI_BVALID,
    input logic S_AXI_BREADY,
    input logic S_AXI_ARVALID,
    input logic S_AXI_ARREADY,
    input logic [31:0] S_AXI_RDATA,
    input logic S_AXI_RVALID,
    input logic S_AXI_RREADY,
    input logic WDT_RESET
);
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (SYS_RST);
    ////////////////////////////////////////////////////////////////
    a_write_busy: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
        else $error("address or data ready while response pending");
    a_bresp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY
        |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
        else $error("write response dropped or changed before taken");
    a_bvalid_drop: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
        else $error("write response stays after handshake");
    a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY
        |=> S_AXI_RVALID && !S_AXI_ARREADY)
        else $error("read data not offered one cycle after address");
    a_rdata_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY
        |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("read data dropped or changed before taken");
    a_rvalid_drop: assert property (S_AXI_RVALID && S_AXI_RREADY
        |=> !S_AXI_RVALID && S_AXI_ARREADY)
        else $error("read channel not released after handshake");
    a_reset_pulse: assert property ($rose(WDT_RESET) |=> !WDT_RESET)
        else $error("watchdog reset wider than one cycle");
    a_stop_freeze: assert property (STOP_MODE [*4] |-> !WDT_RESET)
        else $error("underflow reset while stopped");
endmodule
bind wdt_top wdt_properties i_wdt_properties (.MCLK, .SYS_RST, .STOP_MODE, .S_AXI_AWREADY,
    .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARVALID,
    .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RVALID, .S_AXI_RREADY, .WDT_RESET);

// ===== verification/testbench.sv
// Self-checking bench for the watchdog block
`timescale 1ns/1ns
`include "wdt_defines.vh"
module testbench;
    localparam int CNT = 16;
    typedef struct packed {bit w; logic [7:0] a; logic [31:0] d; logic [31:0] e;
        logic [1:0] r;} wdt_row_t;
    logic mclk = 0, sys_rst = 1, sub = 0, stop_m = 0, wait_m = 0;
    logic awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, h;
    logic [7:0] strap = 8'h01, awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0, got, c1;
    logic [1:0] resp, sc = 2'h0;
    wire awr, wr_r, bv, arr, rv, irq, wrst;
    wire [1:0] br, rr;
    wire [31:0] rd;
    int n_mismatch = 0, n_tests = 0, n, dv;
    wdt_row_t rows [11] = '{
        '{0, `WDT_ADDR_OPTION, 0, 32'h1, 0}, '{1, `WDT_ADDR_OPTION, 32'hFF, 0, 0},
        '{0, `WDT_ADDR_OPTION, 0, 32'h1, 0}, '{0, `WDT_ADDR_STATE, 0, 32'h2, 0},
        '{1, `WDT_ADDR_MASK, 32'h3, 0, 0}, '{0, `WDT_ADDR_MASK, 0, 32'h3, 0},
        '{1, `WDT_ADDR_CONTROL, 32'h1F, 0, 0}, '{0, `WDT_ADDR_CONTROL, 0, 32'h1F, 0},
        '{0, `WDT_ADDR_REFRESH, 0, 0, 0}, '{0, 8'h20, 0, 0, 2}, '{1, 8'h20, 32'h5, 0, 2}};
    wdt_top #(.DIV_FAST(4), .DIV_SLOW(8), .DIV_SUB(2), .CNT_CPU(16'h0010)) i_wdt_top (
        .MCLK(mclk), .SYS_RST(sys_rst), .STARTUP_OPTION_BYTE(strap), .SUBCLOCK_INPUT(sub),
        .STOP_MODE(stop_m), .WAIT_MODE(wait_m), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
        .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv),
        .S_AXI_WREADY(wr_r), .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(bre),
        .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rd),
        .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rre), .WDT_IRQ(irq),
        .WDT_RESET(wrst));
    always #25 mclk = ~mclk;
    // Sub-clock with a rising edge every 8 cycles
    always @(posedge mclk)
    begin
        sc <= sc + 2'h1;
        if (sc == 2'h3)
            sub <= ~sub;
    end
    ////////////////////////////////////////////////////////////////
    task automatic final_report;
        $display("mismatches %0d, checks %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic tmo(input int i, input int lim);
        if (i >= lim)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: wait ran out", $time);
            final_report;
        end
    endtask
    // Write and read hold ready back two cycles to exercise stalls
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int i;
        i = 0;
        awa <= a;
        wd <= d;
        awv <= 1;
        wv <= 1;
        do
        begin
            @(posedge mclk);
            if (awr) awv <= 0;
            if (wr_r) wv <= 0;
            h = bv && bre;
            bre <= !h && i > 1;
            resp = br;
            i++;
        end while (!h && i < 50);
        tmo(i, 50);
    endtask
    task automatic rdr(input logic [7:0] a, output logic [31:0] d);
        int i;
        i = 0;
        ara <= a;
        arv <= 1;
        do
        begin
            @(posedge mclk);
            if (arr) arv <= 0;
            h = rv && rre;
            rre <= !h && i > 1;
            d = rd;
            resp = rr;
            i++;
        end while (!h && i < 50);
        tmo(i, 50);
    endtask
    task automatic refresh;
        wr(`WDT_ADDR_REFRESH, 32'h0);
        wr(`WDT_ADDR_REFRESH, 32'hFF);
    endtask
    task automatic do_reset(input logic [7:0] s);
        strap <= s;
        sys_rst <= 1;
        repeat (16) @(posedge mclk);
        sys_rst <= 0;
        repeat (2) @(posedge mclk);
    endtask
    ////////////////////////////////////////////////////////////////
    initial
    begin
        do_reset(8'h01);
        foreach (rows[k])
        begin
            if (rows[k].w) wr(rows[k].a, rows[k].d); else rdr(rows[k].a, got);
            chk(resp, rows[k].r);
            if (!rows[k].w) chk(got, rows[k].e);
        end
        rdr(`WDT_ADDR_COUNT, c1);
        chk(c1, `WDT_CNT_CPU);
        repeat (100) @(posedge mclk);
        rdr(`WDT_ADDR_COUNT, got);
        chk(got, c1);
        wr(`WDT_ADDR_START, 32'h0);
        rdr(`WDT_ADDR_STATE, got);
        chk(got[0], 1);
        for (int d = 0; d < 2; d++)
        begin
            dv = d ? 8 : 4;
            wr(`WDT_ADDR_CONTROL, d);
            wr(`WDT_ADDR_MASK, 32'h1);
            wr(`WDT_ADDR_STATUS, 32'h3);
            refresh();
            n = 0;
            while (!irq && n < 3000)
            begin
                @(posedge mclk);
                n++;
            end
            tmo(n, 3000);
            chk(n >= CNT * dv - 2 && n <= CNT * dv + dv + 1, 1);
            wr(`WDT_ADDR_MASK, 32'h0);
            repeat (2) @(posedge mclk);
            chk(irq, 0);
            rdr(`WDT_ADDR_STATUS, got);
            chk(got[0], 1);
        end
        wr(`WDT_ADDR_STATUS, 32'h3);
        wr(`WDT_ADDR_REFRESH, 32'hFF);
        rdr(`WDT_ADDR_STATUS, got);
        chk(got[1:0], 2'h2);
        wr(`WDT_ADDR_STATUS, 32'h2);
        wr(`WDT_ADDR_REFRESH, 32'h0);
        rdr(`WDT_ADDR_STATE, got);
        chk(got[2], 1);
        wr(`WDT_ADDR_REFRESH, 32'h55);
        wr(`WDT_ADDR_REFRESH, 32'hFF);
        rdr(`WDT_ADDR_STATUS, got);
        chk(got[1], 1);
        wr(`WDT_ADDR_CONTROL, 32'h10);
        wr(`WDT_ADDR_STATUS, 32'h3);
        wr(`WDT_ADDR_MASK, 32'h1);
        n = 0;
        while (!wrst && n < 3000)
        begin
            @(posedge mclk);
            n++;
        end
        tmo(n, 3000);
        rdr(`WDT_ADDR_STATUS, got);
        chk({got[0], irq}, 2'h0);
        // Wait then stop with each source: expected change flags
        for (int m = 0; m < 4; m++)
        begin
            wr(`WDT_ADDR_CONTROL, m[1] ? 32'h2 : 32'h0);
            wait_m <= !m[0];
            stop_m <= m[0];
            rdr(`WDT_ADDR_COUNT, c1);
            repeat (200) @(posedge mclk);
            rdr(`WDT_ADDR_COUNT, got);
            chk(got != c1, m == 2);
        end
        for (int v = 0; v < 4; v++)
        begin
            wr(`WDT_ADDR_CONTROL, (v << 2) | 2);
            refresh();
            rdr(`WDT_ADDR_COUNT, got);
            chk(got, 32'h200 << v);
        end
        // Still frozen: an unarmed FFh must not load the smaller start value
        wr(`WDT_ADDR_CONTROL, 32'h2);
        wr(`WDT_ADDR_REFRESH, 32'h55);
        wr(`WDT_ADDR_REFRESH, 32'hFF);
        rdr(`WDT_ADDR_COUNT, got);
        chk(got, `WDT_CNT_SUB3);
        stop_m <= 0;
        wait_m <= 0;
        do_reset(8'h00);
        rdr(`WDT_ADDR_STATE, got);
        chk(got[1:0], 2'h1);
        rdr(`WDT_ADDR_COUNT, c1);
        repeat (20) @(posedge mclk);
        rdr(`WDT_ADDR_COUNT, got);
        chk(got != c1, 1);
        final_report;
    end
endmodule
